// ### ddr2bc_column.sv
// Column-access and burst engine of a four-bank x8 DDR2 device.
// Assumes all pins come from outside the core_clk domain; the link
// clock ck is sampled like any pin and runs well below core_clk.

module ddr2bc_column
  import ddr2bc_pkg::*;
(
  // Core clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // Command pins
  input wire logic ck,
  input wire logic cke,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [1:0] ba,
  input wire logic [13:0] addr,
  // Data pins
  input wire logic [7:0] dq_in,
  output logic [7:0] dq_out,
  output logic dq_oe,
  input wire logic dqs_in,
  output logic dqs_out,
  output logic dqs_oe,
  input wire logic write_mask,
  // Mode settings
  input wire logic [2:0] cas_latency,
  input wire logic [2:0] additive_latency,
  input wire logic [2:0] burst_len_code,
  input wire logic burst_interleave,
  input wire logic redundant_read_strobe_en,
  // Status
  output logic read_active,
  output logic write_active
);

  // ****************************************************************
  // Functions
  // ****************************************************************

  // Command decode from the sampled strobes
  function automatic ddr2bc_cmd_t decode_cmd(
    input logic en, input logic cs, input logic ras,
    input logic cas, input logic we);
    if (!en || cs) begin
      decode_cmd = DDR2BC_CMD_NOP;
    end else if (ras && cas && we) begin
      decode_cmd = DDR2BC_CMD_NOP;
    end else if (ras && !cas) begin
      decode_cmd = we ? DDR2BC_CMD_READ : DDR2BC_CMD_WRITE;
    end else begin
      decode_cmd = DDR2BC_CMD_OTHER;
    end
  endfunction

  // Column of one beat, kept inside the aligned segment
  function automatic logic [`DDR2BC_COL_W-1:0] col_of(
    input logic [`DDR2BC_COL_W-1:0] start, input logic [3:0] beat,
    input logic bl8, input logic il);
    logic [2:0] off;
    off = start[2:0];
    if (il) begin
      off = start[2:0] ^ beat[2:0];
    end else begin
      off[1:0] = start[1:0] + beat[1:0];
      off[2] = start[2] ^ beat[2];
    end
    // Upper bits stay: the burst never leaves its segment
    if (bl8) begin
      col_of = {start[9:3], off};
    end else begin
      col_of = {start[9:2], off[1:0]};
    end
  endfunction

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************

  logic [`DDR2BC_SYNC_W-1:0] pin_raw; // All pins, one bundle
  logic [`DDR2BC_SYNC_W-1:0] pin_s1_q; // First stage, read by s2 only
  logic [`DDR2BC_SYNC_W-1:0] pin_s2_q; // Second stage, safe to use

  assign pin_raw = {ck, cke, cs_n, ras_n, cas_n, we_n, ba, addr,
                    dq_in, dqs_in, write_mask, cas_latency,
                    additive_latency, burst_len_code, burst_interleave,
                    redundant_read_strobe_en};

  // Two flops on every pin; data and strobes share the same delay
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      pin_s1_q <= '0;
      pin_s2_q <= '0;
    end else begin
      pin_s1_q <= pin_raw;
      pin_s2_q <= pin_s1_q;
    end
  end

  logic ck_s, cke_s, cs_s, ras_s, cas_s, we_s, dqs_s, mask_s;
  logic [1:0] ba_s;
  logic [13:0] addr_s;
  logic [7:0] dq_s;
  logic [2:0] cl_s, al_s, blc_s;
  logic il_s, rrs_s;

  assign {ck_s, cke_s, cs_s, ras_s, cas_s, we_s, ba_s, addr_s,
          dq_s, dqs_s, mask_s, cl_s, al_s, blc_s, il_s,
          rrs_s} = pin_s2_q;

  logic ck_prev_q; // Link clock one sample back
  logic dqs_prev_q; // Write strobe one sample back

  // Edge finders on the synchronised clock and strobe
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      ck_prev_q <= 1'b0;
      dqs_prev_q <= 1'b0;
    end else begin
      ck_prev_q <= ck_s;
      dqs_prev_q <= dqs_s;
    end
  end

  logic ck_rise, ck_edge, dqs_rise, dqs_edge;
  assign ck_rise = ck_s & ~ck_prev_q;
  assign ck_edge = ck_s ^ ck_prev_q;
  assign dqs_rise = dqs_s & ~dqs_prev_q;
  assign dqs_edge = dqs_s ^ dqs_prev_q;

  // ****************************************************************
  // Mode and latency
  // ****************************************************************

  logic bl8; // Eight-beat bursts selected
  logic [3:0] bl_beats; // Beats in one burst
  logic [2:0] al_eff; // Additive latency, clipped
  logic [2:0] cl_eff; // CAS latency, floored
  logic [3:0] rl; // Read latency in link clocks
  logic [3:0] wl; // Write latency in link clocks

  // Unsupported length codes fall back to four beats
  assign bl8 = (blc_s == `DDR2BC_BL8_CODE);
  assign bl_beats = bl8 ? `DDR2BC_BL8_BEATS : `DDR2BC_BL4_BEATS;
  assign al_eff = (al_s > `DDR2BC_AL_MAX) ? `DDR2BC_AL_MAX : al_s;
  assign cl_eff = (cl_s < `DDR2BC_CL_MIN) ? `DDR2BC_CL_MIN : cl_s;
  assign rl = {1'b0, al_eff} + {1'b0, cl_eff};
  assign wl = rl - 4'h1;

  // ****************************************************************
  // Command decode and posted delay line
  // ****************************************************************

  ddr2bc_cmd_t cmd; // Command seen at this rise
  ddr2bc_slot_t new_slot; // Slot entering the line
  ddr2bc_slot_t pipe_q [0:`DDR2BC_PIPE_DEPTH-1]; // Posted commands

  assign cmd = decode_cmd(cke_s, cs_s, ras_s, cas_s, we_s);

  // Auto-precharge bit is taken by the row logic, not here
  always_comb begin
    new_slot.valid = (cmd == DDR2BC_CMD_READ) ||
                     (cmd == DDR2BC_CMD_WRITE);
    new_slot.write = (cmd == DDR2BC_CMD_WRITE);
    new_slot.bank = ba_s;
    new_slot.col = addr_s[`DDR2BC_COL_W-1:0];
  end

  // Shifts once per link clock rise; slot k is k+1 rises old
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < `DDR2BC_PIPE_DEPTH; i++) begin
        pipe_q[i] <= '0;
      end
    end else if (ck_rise) begin
      pipe_q[0] <= new_slot;
      for (int i = 1; i < `DDR2BC_PIPE_DEPTH; i++) begin
        pipe_q[i] <= pipe_q[i-1];
      end
    end
  end

  ddr2bc_slot_t pre_slot, go_slot, arm_slot;
  logic pre_hit, go_hit, arm_hit;
  assign pre_slot = pipe_q[rl - 4'h2];
  assign go_slot = pipe_q[rl - 4'h1];
  assign arm_slot = pipe_q[wl - 4'h2];
  assign pre_hit = ck_rise & pre_slot.valid & ~pre_slot.write;
  assign go_hit = ck_rise & go_slot.valid & ~go_slot.write;
  assign arm_hit = ck_rise & arm_slot.valid & arm_slot.write;

  // ****************************************************************
  // Array
  // ****************************************************************

  logic [7:0] mem_q [0:`DDR2BC_MEM_WORDS-1]; // Bank and column bytes
  logic wr_take; // Write beat captured now
  logic wr_store; // Captured beat is written
  logic [`DDR2BC_MEM_AW-1:0] wr_addr; // Array index of the beat

  // No reset: the array holds data, not control
  always_ff @(posedge core_clk) begin
    if (wr_store) begin
      mem_q[wr_addr] <= dq_s;
    end
  end

  // ****************************************************************
  // Read output sequencer
  // ****************************************************************

  ddr2bc_rd_state_t rd_state_q;
  logic [1:0] rd_bank_q; // Bank of the running burst
  logic [9:0] rd_start_q; // Starting column of the burst
  logic [3:0] rd_beat_q; // Next beat to drive
  logic [7:0] dq_out_q;
  logic dq_oe_q, dqs_out_q, dqs_oe_q;

  // Beats change on both link clock edges; the strobe high marks
  // even beats. A new read on a rise always wins, so a seamless
  // or interrupting read restarts with no gap.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      rd_state_q <= DDR2BC_RD_IDLE;
      rd_bank_q <= 2'h0;
      rd_start_q <= 10'h000;
      rd_beat_q <= 4'h0;
      dq_out_q <= 8'h00;
      dq_oe_q <= 1'b0;
      dqs_out_q <= 1'b0;
      dqs_oe_q <= 1'b0;
    end else begin
      if (go_hit && rd_state_q != DDR2BC_RD_IDLE) begin
        // First beat with a rising strobe
        rd_state_q <= DDR2BC_RD_DATA;
        rd_bank_q <= go_slot.bank;
        rd_start_q <= go_slot.col;
        rd_beat_q <= 4'h1;
        dq_out_q <= mem_q[{go_slot.bank, go_slot.col}];
        dq_oe_q <= 1'b1;
        dqs_out_q <= 1'b1;
        dqs_oe_q <= 1'b1;
      end else begin
        case (rd_state_q)
          DDR2BC_RD_IDLE: begin
            if (pre_hit) begin
              // Preamble: strobe low one clock ahead
              rd_state_q <= DDR2BC_RD_PRE;
              dqs_oe_q <= 1'b1;
              dqs_out_q <= 1'b0;
            end
          end
          DDR2BC_RD_PRE: begin
            // Waits for the go tap on the next rise
          end
          DDR2BC_RD_DATA: begin
            if (ck_edge && rd_beat_q != bl_beats) begin
              dq_out_q <= mem_q[{rd_bank_q,
                col_of(rd_start_q, rd_beat_q, bl8, il_s)}];
              dqs_out_q <= ~rd_beat_q[0];
              rd_beat_q <= rd_beat_q + 4'h1;
            end else if (pre_hit) begin
              // Next read one clock away: fresh preamble
              rd_state_q <= DDR2BC_RD_PRE;
              dq_oe_q <= 1'b0;
              dqs_out_q <= 1'b0;
            end else if (ck_edge) begin
              // Burst ran its full length with no read at the go tap to cut it
              rd_state_q <= DDR2BC_RD_IDLE;
              dq_oe_q <= 1'b0;
              dqs_out_q <= 1'b0;
              dqs_oe_q <= 1'b0;
            end
          end
          default: begin
            rd_state_q <= DDR2BC_RD_IDLE;
          end
        endcase
      end
    end
  end

  // ****************************************************************
  // Write capture sequencer
  // ****************************************************************

  ddr2bc_wr_state_t wr_state_q;
  logic [1:0] wr_bank_q; // Bank of the burst being captured
  logic [9:0] wr_start_q; // Its starting column
  logic [3:0] wr_beat_q; // Beats captured so far
  logic [1:0] arm_age_q; // Rises since the latest write armed
  logic pend_q; // A further write is waiting
  logic pend_cut_q; // It interrupts at the four-beat mark
  logic [1:0] pend_bank_q;
  logic [9:0] pend_col_q;
  logic [3:0] wr_next; // Beat count after this capture
  logic wr_end; // Current burst ends with this capture

  // First beat only on a rising strobe; later beats on any edge
  assign wr_take = (wr_state_q == DDR2BC_WR_WAIT && dqs_rise) ||
                   (wr_state_q == DDR2BC_WR_DATA && dqs_edge &&
                    wr_beat_q != bl_beats);
  // Mask is sampled with the data; the strobe option overrides it
  assign wr_store = wr_take && !(mask_s && !rrs_s);
  assign wr_addr = {wr_bank_q,
                    col_of(wr_start_q, wr_beat_q, bl8, il_s)};
  assign wr_next = wr_beat_q + 4'h1;
  assign wr_end = wr_take && (wr_next == bl_beats ||
    (pend_q && pend_cut_q && wr_next == `DDR2BC_HALF_BEATS));

  // Age of the latest armed write, saturating
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      arm_age_q <= 2'h3;
    end else if (arm_hit) begin
      arm_age_q <= 2'h1;
    end else if (ck_rise && arm_age_q != 2'h3) begin
      arm_age_q <= arm_age_q + 2'h1;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_state_q <= DDR2BC_WR_IDLE;
      wr_bank_q <= 2'h0;
      wr_start_q <= 10'h000;
      wr_beat_q <= 4'h0;
      pend_q <= 1'b0;
      pend_cut_q <= 1'b0;
      pend_bank_q <= 2'h0;
      pend_col_q <= 10'h000;
    end else begin
      case (wr_state_q)
        DDR2BC_WR_IDLE, DDR2BC_WR_WAIT: begin
          if (arm_hit) begin
            // Armed one clock before the first strobe edge
            wr_state_q <= DDR2BC_WR_WAIT;
            wr_bank_q <= arm_slot.bank;
            wr_start_q <= arm_slot.col;
            wr_beat_q <= 4'h0;
          end else if (wr_take) begin
            wr_state_q <= DDR2BC_WR_DATA;
            wr_beat_q <= 4'h1;
          end
        end
        DDR2BC_WR_DATA: begin
          if (wr_end) begin
            // Hand over to a waiting write, else stop listening
            if (arm_hit) begin
              wr_bank_q <= arm_slot.bank;
              wr_start_q <= arm_slot.col;
              wr_beat_q <= 4'h0;
            end else if (pend_q) begin
              wr_bank_q <= pend_bank_q;
              wr_start_q <= pend_col_q;
              wr_beat_q <= 4'h0;
              pend_q <= 1'b0;
            end else begin
              wr_state_q <= DDR2BC_WR_IDLE;
              wr_beat_q <= wr_next;
            end
          end else begin
            if (wr_take) begin
              wr_beat_q <= wr_next;
            end
            if (arm_hit) begin
              // A write two clocks after the last one cuts in
              pend_q <= 1'b1;
              pend_cut_q <= (arm_age_q == `DDR2BC_COL_GAP);
              pend_bank_q <= arm_slot.bank;
              pend_col_q <= arm_slot.col;
            end
          end
        end
        default: begin
          wr_state_q <= DDR2BC_WR_IDLE;
        end
      endcase
    end
  end

  // ****************************************************************
  // Status and outputs
  // ****************************************************************

  logic read_active_q, write_active_q;

  // Busy flags lag the sequencers by one core clock
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      read_active_q <= 1'b0;
      write_active_q <= 1'b0;
    end else begin
      read_active_q <= (rd_state_q != DDR2BC_RD_IDLE);
      write_active_q <= (wr_state_q != DDR2BC_WR_IDLE);
    end
  end

  assign dq_out = dq_out_q;
  assign dq_oe = dq_oe_q;
  assign dqs_out = dqs_out_q;
  assign dqs_oe = dqs_oe_q;
  assign read_active = read_active_q;
  assign write_active = write_active_q;

endmodule

// ### ddr2bc_regs.svh
// Constants for the DDR2 column-access and burst engine.
// Assumes inclusion by its bare name from the package only.
`ifndef DDR2BC_REGS_SVH
`define DDR2BC_REGS_SVH

// Column address width of one open page
`define DDR2BC_COL_W 10
// Bank select width
`define DDR2BC_BANK_W 2
// Array index width, bank above column
`define DDR2BC_MEM_AW 12
// Number of bytes held by the array model
`define DDR2BC_MEM_WORDS 4096
// Burst length field codes of the mode register
`define DDR2BC_BL4_CODE 3'h2
`define DDR2BC_BL8_CODE 3'h3
// Beat counts per burst length, and the interrupt boundary
`define DDR2BC_BL4_BEATS 4'h4
`define DDR2BC_BL8_BEATS 4'h8
`define DDR2BC_HALF_BEATS 4'h4
// Largest additive latency, least usable CAS latency
`define DDR2BC_AL_MAX 3'h6
`define DDR2BC_CL_MIN 3'h3
// Posted command delay line length, in link clocks
`define DDR2BC_PIPE_DEPTH 16
// Least column-to-column gap, in link clocks
`define DDR2BC_COL_GAP 2'h2
// Auto-precharge address bit
`define DDR2BC_AP_BIT 10
// Width of the bundle of synchronised pins
`define DDR2BC_SYNC_W 43

`endif

// ### ddr2bc_pkg.sv
// Types shared by the DDR2 column-access and burst engine.
// Assumes ddr2bc_regs.svh sits in the include path.
package ddr2bc_pkg;

`include "ddr2bc_regs.svh"

  // Decoded command on one link clock rise
  typedef enum logic [1:0] {
    DDR2BC_CMD_NOP,
    DDR2BC_CMD_READ,
    DDR2BC_CMD_WRITE,
    DDR2BC_CMD_OTHER
  } ddr2bc_cmd_t;

  // One slot of the posted command delay line
  typedef struct packed {
    logic valid;
    logic write;
    logic [`DDR2BC_BANK_W-1:0] bank;
    logic [`DDR2BC_COL_W-1:0] col;
  } ddr2bc_slot_t;

  // Read output sequencer
  typedef enum logic [1:0] {
    DDR2BC_RD_IDLE,
    DDR2BC_RD_PRE,
    DDR2BC_RD_DATA
  } ddr2bc_rd_state_t;

  // Write capture sequencer
  typedef enum logic [1:0] {
    DDR2BC_WR_IDLE,
    DDR2BC_WR_WAIT,
    DDR2BC_WR_DATA
  } ddr2bc_wr_state_t;

endpackage

// ### ddr2bc_column_chk.sv
// Checker of the column engine's read strobe and data pins.
// Assumes it is bound to ddr2bc_column and sees only its ports.
module ddr2bc_column_chk
  import ddr2bc_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // Command pins
  input wire logic cke,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  // Read pins
  input wire logic [7:0] dq_out,
  input wire logic dq_oe,
  input wire logic dqs_out,
  input wire logic dqs_oe
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!reset_n);
  // Core cycles since a read was last on the pins; saturates so a
  // long idle stretch cannot wrap back into the checked window
  logic [7:0] quiet_q;
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      quiet_q <= 8'h00;
    end else if (cke && !cs_n && ras_n && !cas_n && we_n) begin
      quiet_q <= 8'h00;
    end else if (quiet_q != 8'hFF) begin
      quiet_q <= quiet_q + 8'h01;
    end
  end
  // ************
  // Read bursts
  // ************
  sequence s_preamble;
    (dqs_oe && !dqs_out && !dq_oe) [*6];
  endsequence
  sequence s_first_beat;
    dq_oe && dqs_out;
  endsequence
  property p_preamble;
    $rose(dqs_oe) |-> s_preamble ##[1:4] s_first_beat;
  endproperty
  a_preamble: assert property (p_preamble)
    else $error("read preamble wrong");
  property p_oe_pair;
    dq_oe |-> dqs_oe;
  endproperty
  a_oe_pair: assert property (p_oe_pair)
    else $error("data driven without strobe");
  property p_beat_hold;
    dq_oe && $changed(dqs_out) |=> $stable(dqs_out) [*3];
  endproperty
  a_beat_hold: assert property (p_beat_hold)
    else $error("read beat too short");
  property p_data_moves;
    dq_oe && $changed(dq_out) |-> $changed(dqs_out);
  endproperty
  a_data_moves: assert property (p_data_moves)
    else $error("read data moved off strobe edge");
  // A read one clock behind keeps the strobe driven as its preamble,
  // so only the strobe level is fixed when the data lines let go
  property p_drop;
    $fell(dq_oe) |-> !dqs_out;
  endproperty
  a_drop: assert property (p_drop)
    else $error("strobe left high after burst");
  property p_min_burst;
    $rose(dq_oe) |-> dq_oe [*8] ##1 dq_oe [*8];
  endproperty
  a_min_burst: assert property (p_min_burst)
    else $error("read burst shorter than four beats");
  property p_no_stray;
    quiet_q == 8'hFF |-> !dqs_oe && !dq_oe;
  endproperty
  a_no_stray: assert property (p_no_stray)
    else $error("pins driven with no read");
  property p_reset_quiet;
    $rose(reset_n) |-> !dqs_oe && !dq_oe;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet)
    else $error("pins driven after reset");
endmodule

bind ddr2bc_column ddr2bc_column_chk i_ddr2bc_column_chk (
  .core_clk, .reset_n, .cke, .cs_n, .ras_n, .cas_n, .we_n,
  .dq_out, .dq_oe, .dqs_out, .dqs_oe
);

// ### ddr2bc_ctrl_model.sv
// Behavioural DDR2 controller driving the engine's link pins.
// Assumes one caller at a time; issues no stop or precharge.
// Sends no activate, so no column command beats that delay.
module ddr2bc_ctrl_model
  import ddr2bc_pkg::*;
(
  // Link clock and command
  output logic ck,
  output logic cke,
  output logic cs_n,
  output logic ras_n,
  output logic cas_n,
  output logic we_n,
  output logic [1:0] ba,
  output logic [13:0] addr,
  // Write data, strobe and mask
  output logic [7:0] dq,
  output logic dqs,
  output logic write_mask
);
  timeunit 1ns;
  timeprecision 100ps;
  int rises;  // Link clock rises so far
  // The link clock runs free, 64 ns, phase unrelated to core_clk
  initial begin
    {ck, cke, cs_n, ras_n, cas_n, we_n} = 6'h1F;
    {ba, addr, dq, dqs, write_mask} = 26'h0000000;
    rises = 0;
    #3;
    forever #32 ck = ~ck;
  end
  always @(posedge ck) begin
    rises <= rises + 1;
  end
  // One command held a full clock about a rise; cmd is
  // {cke, cs_n, ras_n, cas_n, we_n}. Returning on a fall keeps
  // any two commands two clocks apart.
  task automatic command(input logic [4:0] cmd, input logic [1:0] b,
                         input logic [13:0] a, output int at);
    @(negedge ck);
    {cke, cs_n, ras_n, cas_n, we_n} <= cmd;
    {ba, addr} <= {b, a};
    @(posedge ck);
    #1 at = rises;
    @(negedge ck);
    // Deselected, with the other pins turned over
    {cke, cs_n, ras_n, cas_n, we_n} <= {2'h3, ~cmd[2:0]};
    {ba, addr} <= ~{b, a};
  endtask
  // Write with no auto-precharge; strobe rests low by termination
  task automatic write_burst(input logic [1:0] b, input logic [9:0] s,
                             input int n, wl, input logic [63:0] d,
                             input logic [7:0] m);
    int at;
    command(5'h14, b, {4'hA, s}, at);
    repeat (wl - 1) @(negedge ck);  // Preamble half a clock ahead
    for (int k = 0; k < n; k++) begin
      #16;
      dq <= d[8*k +: 8];
      write_mask <= m[k];
      #16;
      dqs <= ~k[0];
    end
    #16;
    // Junk after the burst must not land in the array
    dq <= ~dq;
    write_mask <= ~write_mask;
  endtask
endmodule

// ### testbench.sv
// Self-checking bench of the column engine and a controller model.
// Assumes the model's link clock runs free from time zero.
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  // Clock, reset and mode settings
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [2:0] cas_latency = 3'h3;
  logic [2:0] additive_latency = 3'h0;
  logic [2:0] burst_len_code = 3'h2;
  logic burst_interleave = 1'b0;
  logic redundant_read_strobe_en = 1'b0;
  // Link pins; the shared lines resolve from both enables
  logic ck, cke, cs_n, ras_n, cas_n, we_n, dqs_m, write_mask;
  logic dq_oe, dqs_out, dqs_oe, read_active, write_active;
  logic rd_seen = 1'b0, wr_seen = 1'b0;
  logic [1:0] ba;
  logic [13:0] addr;
  logic [7:0] dq_m, dq_out;
  wire logic [7:0] dq_in = dq_oe ? dq_out : dq_m;
  wire logic dqs_in = dqs_oe ? dqs_out : dqs_m;
  // Bench state
  logic [7:0] mem_exp [0:4095];
  logic [7:0] got_q [$];
  logic [15:0] rnd_q = 16'hBEC5;
  logic m_bl8, m_il, m_rrs, prev_oe, prev_dqs;
  logic [2:0] m_al, m_cl;
  int first_rise, fail_count = 0, checks_done = 0, cycles = 0;

  ddr2bc_column i_ddr2bc_column (
    .core_clk, .reset_n, .ck, .cke, .cs_n, .ras_n, .cas_n, .we_n, .ba,
    .addr, .dq_in, .dq_out, .dq_oe, .dqs_in, .dqs_out, .dqs_oe,
    .write_mask, .cas_latency, .additive_latency, .burst_len_code,
    .burst_interleave, .redundant_read_strobe_en, .read_active,
    .write_active
  );
  ddr2bc_ctrl_model i_ddr2bc_ctrl_model (
    .ck, .cke, .cs_n, .ras_n, .cas_n, .we_n, .ba, .addr, .dq(dq_m),
    .dqs(dqs_m), .write_mask
  );

  always #4 core_clk = ~core_clk;
  // **********
  // Helpers
  // **********
  function automatic logic [15:0] lfsr(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  // Column of beat k; upper bits never move
  function automatic logic [9:0] beat_col(input logic [9:0] s,
                                          input int k, input logic bl8, il);
    logic [9:0] c;
    c = s;
    c[1:0] = il ? s[1:0] ^ k[1:0] : s[1:0] + k[1:0];
    if (bl8) c[2] = s[2] ^ k[2];
    return c;
  endfunction
  task automatic cmp_byte(input string what, input logic [7:0] e, g);
    checks_done++;
    if (g !== e) begin
      fail_count++;
      $display("unexpected %s: expected %h, seen %h", what, e, g);
    end
  endtask
  task automatic cmp_bit(input string what, input logic e, g);
    checks_done++;
    if (g !== e) begin
      fail_count++;
      $display("unexpected %s: expected %b, seen %b", what, e, g);
    end
  endtask
  task automatic cmp_num(input string what, input int e, g);
    checks_done++;
    if (g != e) begin
      fail_count++;
      $display("unexpected %s: expected %0d, seen %0d", what, e, g);
    end
  endtask
  task automatic complete_run;
    $display("checks %0d, mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // Collect one byte per strobe edge while the engine drives; looked
  // at on the falling core edge, once the launched values have settled
  always @(negedge core_clk) begin
    if (dq_oe === 1'b1 &&
        (prev_oe !== 1'b1 || dqs_out !== prev_dqs)) begin
      if (got_q.size() == 0) first_rise = i_ddr2bc_ctrl_model.rises;
      got_q.push_back(dq_out);
    end
    if (read_active === 1'b1) rd_seen = 1'b1;
    if (write_active === 1'b1) wr_seen = 1'b1;
    prev_oe = dq_oe;
    prev_dqs = dqs_out;
  end
  // Hang guard, well above the few thousand cycles needed
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 60000) begin
      fail_count++;
      complete_run();
    end
  end
  task automatic set_mode(input logic bl8, il, rrs, input logic [2:0] al, cl);
    {m_bl8, m_il, m_rrs, m_al, m_cl} = {bl8, il, rrs, al, cl};
    @(posedge core_clk);
    burst_len_code <= bl8 ? 3'h3 : 3'h2;
    burst_interleave <= il;
    redundant_read_strobe_en <= rrs;
    additive_latency <= al;
    cas_latency <= cl;
    repeat (4) @(posedge core_clk);
  endtask
  task automatic wr(input logic [1:0] b, input logic [9:0] s,
                    input logic [7:0] mk);
    logic [63:0] d;
    for (int k = 0; k < (m_bl8 ? 8 : 4); k++) begin
      rnd_q = lfsr(rnd_q);
      d[8*k +: 8] = rnd_q[7:0];
      if (!mk[k] || m_rrs) mem_exp[{b, beat_col(s, k, m_bl8, m_il)}] = d[8*k +: 8];
    end
    wr_seen = 1'b0;
    i_ddr2bc_ctrl_model.write_burst(b, s, m_bl8 ? 8 : 4,
                                    m_al + m_cl - 1, d, mk);
    repeat (4) @(posedge core_clk);
    cmp_bit("write busy", 1'b1, wr_seen);
    cmp_bit("write idle", 1'b0, write_active);
  endtask
  // One read, or two reads two clocks apart when two is set
  task automatic rd_check(input logic [1:0] b0, b1, input logic [9:0] s0, s1,
                          input logic two);
    int at0, at1, n;
    logic [7:0] exp_q [$];
    n = m_bl8 ? 8 : 4;
    for (int k = 0; k < (two ? 4 : n); k++) exp_q.push_back(mem_exp[{b0, beat_col(s0, k, m_bl8, m_il)}]);
    for (int k = 0; k < (two ? n : 0); k++) exp_q.push_back(mem_exp[{b1, beat_col(s1, k, m_bl8, m_il)}]);
    got_q.delete();
    rd_seen = 1'b0;
    rnd_q = lfsr(rnd_q);
    i_ddr2bc_ctrl_model.command(5'h15, b0, {rnd_q[3:1], 1'b0, s0}, at0);
    if (two) i_ddr2bc_ctrl_model.command(5'h15, b1, {rnd_q[7:4], s1}, at1);
    for (int i = 0; i < 600 && got_q.size() < exp_q.size(); i++) @(posedge core_clk);
    repeat (40) @(posedge core_clk);
    cmp_bit("read busy", 1'b1, rd_seen);
    cmp_bit("read idle", 1'b0, read_active);
    cmp_num("read latency", m_al + m_cl, first_rise - at0);
    cmp_num("beat count", exp_q.size(), got_q.size());
    for (int k = 0; k < exp_q.size(); k++) cmp_byte("read beat", exp_q[k], got_q[k]);
  endtask
  // **********
  // Scenarios
  // **********
  initial begin
    logic [2:0] al;
    logic [1:0] b;
    logic [9:0] s;
    logic [4:0] cmds [4];
    int at;
    cmds = '{5'h17, 5'h07, 5'h1D, 5'h05};
    repeat (5) @(posedge core_clk);
    reset_n <= 1'b1;
    // Every length and order; random latencies, additive latency corners at the ends
    for (int i = 0; i < 8; i++) begin
      rnd_q = lfsr(rnd_q);
      al = (i == 0) ? 3'h0 : (i == 7) ? 3'h6 : 3'(rnd_q[15:8] % 7);
      set_mode(i[1], i[0], 1'b0, al, 3'(3 + rnd_q[1:0] % 3));
      {b, s} = {rnd_q[5:4], rnd_q[15:6]};
      wr(b, s, 8'h00);
      rd_check(b, b, s ^ {7'h0, rnd_q[2:0] & (m_bl8 ? 3'h7 : 3'h3)}, s, 1'b0);
    end
    // Masked bytes keep old data unless the mask is disabled
    set_mode(1'b0, 1'b0, 1'b0, 3'h0, 3'h3);
    wr(2'h1, 10'h3F6, 8'h00);
    wr(2'h1, 10'h3F6, {4'h0, rnd_q[11:9], 1'b1});
    rd_check(2'h1, 2'h1, 10'h3F4, 10'h3F4, 1'b0);
    set_mode(1'b0, 1'b1, 1'b1, 3'h2, 3'h4);
    wr(2'h1, 10'h3F5, 8'hFF);
    rd_check(2'h1, 2'h1, 10'h3F7, 10'h3F7, 1'b0);
    // No-op, low enable, deselected read, read with enable low
    got_q.delete();
    rd_seen = 1'b0;
    for (int j = 0; j < 4; j++) begin
      i_ddr2bc_ctrl_model.command(cmds[j], 2'h2, 14'h0040, at);
    end
    repeat (300) @(posedge core_clk);
    cmp_num("stray beats", 0, got_q.size());
    cmp_bit("stray busy", 1'b0, rd_seen);
    // Eight-beat read cut by a read, then seamless four-beat reads
    set_mode(1'b1, 1'b0, 1'b0, 3'h1, 3'h3);
    wr(2'h2, 10'h040, 8'h00);
    wr(2'h3, 10'h085, 8'h00);
    rd_check(2'h2, 2'h3, 10'h042, 10'h087, 1'b1);
    set_mode(1'b0, 1'b1, 1'b0, 3'h0, 3'h3);
    rd_check(2'h3, 2'h2, 10'h086, 10'h041, 1'b1);
    complete_run();
  end
endmodule
